// ===== bcr_backend_model.sv
// behavioural model of the acquisition back end: calibration engine and converter clocks
`timescale 1ns/1ps
module bcr_backend_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input bcr_pkg::bcr_pulse_t pulses,
  input bcr_pkg::bcr_ctrl_t ctrl,
  input wire logic fail_next,
  input wire logic [7:0] cal_cycles,
  output logic cal_done,
  output logic cal_fail,
  output logic clocks_stable
);
  // ----------------------------------------------------------------
  // calibration run and clock settling
  // ----------------------------------------------------------------
  logic [7:0] cal_cnt;
  logic [3:0] settle_cnt;
  bcr_pkg::bcr_ctrl_t ctrl_q;
  wire logic param_change = (ctrl_q != ctrl) || pulses.board_init;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cal_cnt <= 8'h00;
      cal_done <= 1'b0;
      cal_fail <= 1'b0;
      settle_cnt <= 4'h0;
      clocks_stable <= 1'b1;
    end else begin
      if (pulses.cal_start) begin
        cal_cnt <= cal_cycles;
        cal_done <= 1'b0;
        cal_fail <= 1'b0;
      end else if (cal_cnt == 8'h01) begin
        cal_cnt <= 8'h00;
        cal_done <= 1'b1;
        cal_fail <= fail_next;
      end else if (cal_cnt != 8'h00) begin
        cal_cnt <= cal_cnt - 8'h01;
      end
      // clocks drop out on a parameter change and settle some cycles later
      if (param_change) begin
        settle_cnt <= 4'h8;
        clocks_stable <= 1'b0;
      end else if (settle_cnt != 4'h0) begin
        settle_cnt <= settle_cnt - 4'h1;
      end else begin
        clocks_stable <= 1'b1;
      end
    end
  end

  // previous control image, tracked through reset so release shows no change
  always_ff @(posedge clk_sys) begin
    ctrl_q <= ctrl;
  end
endmodule

// ===== bcr_board_control.sv
// board control register: mode fields, action bits and status reporting
`timescale 1ns/1ps
module bcr_board_control #(
  parameter bit LOW_POWER = 1'b0,
  parameter int DIV_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic irq_event,
  input wire logic cal_done,
  input wire logic cal_fail,
  input wire logic clocks_stable,
  input wire logic buf_above_thresh,
  input wire logic buf_full,
  input wire logic rate_a_tick,
  input wire logic group0_tick,
  input wire logic [3:0] group0_rate_src,
  input wire logic [DIV_WIDTH-1:0] group0_div,
  output bcr_pkg::bcr_ctrl_t ctrl,
  output bcr_pkg::bcr_pulse_t pulses,
  output logic irq_out,
  output logic ext_clk_out
);

  // ----------------------------------------------------------------
  // elaboration checks and reset values
  // ----------------------------------------------------------------
  initial begin
    if (DIV_WIDTH < 5) begin
      $error("bcr_board_control: DIV_WIDTH must hold divisors up to 25");
    end
  end

  localparam logic [31:0] RESET_VAL = LOW_POWER ? bcr_pkg::RESET_LOWPWR : bcr_pkg::RESET_STD;
  localparam bcr_pkg::bcr_ctrl_t RESET_CTRL = '{
    input_mode: RESET_VAL[bcr_pkg::INPUT_MODE_LSB +: 2],
    input_span: RESET_VAL[bcr_pkg::INPUT_SPAN_LSB +: 2],
    offset_binary: RESET_VAL[bcr_pkg::OFFSET_BINARY_BIT],
    initiator: RESET_VAL[bcr_pkg::INITIATOR_BIT],
    irq_event_sel: RESET_VAL[bcr_pkg::IRQ_SEL_LSB +: 3],
    unsynced_sampling: RESET_VAL[bcr_pkg::UNSYNCED_BIT],
    clear_on_sync: RESET_VAL[bcr_pkg::CLR_ON_SYNC_BIT],
    clock_out_source_sel: RESET_VAL[bcr_pkg::CLK_OUT_SEL_BIT],
    low_freq_filter: RESET_VAL[bcr_pkg::LOW_FILTER_BIT],
    ttl_sync_io: RESET_VAL[bcr_pkg::TTL_SYNC_BIT],
    arm_ext_trigger: RESET_VAL[bcr_pkg::ARM_TRIG_BIT]};

  // ----------------------------------------------------------------
  // synchronised status inputs
  // ----------------------------------------------------------------
  logic [5:0] status_raw;
  logic [5:0] status_sync;
  logic irq_event_s;
  logic cal_done_s;
  logic cal_fail_s;
  logic clocks_stable_s;
  logic above_thresh_s;
  logic buf_full_s;

  assign status_raw = {irq_event, cal_done, cal_fail, clocks_stable, buf_above_thresh, buf_full};

  bcr_sync2 #(
    .WIDTH(6)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(status_raw),
    .q(status_sync)
  );

  assign irq_event_s = status_sync[5];
  assign cal_done_s = status_sync[4];
  assign cal_fail_s = status_sync[3];
  assign clocks_stable_s = status_sync[2];
  assign above_thresh_s = status_sync[1];
  assign buf_full_s = status_sync[0];

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  bcr_pkg::bcr_ctrl_t ctrl_reg;
  bcr_pkg::bcr_ctrl_t ctrl_next;
  logic sync_reg;
  logic cal_reg;
  logic cal_next;
  logic cal_done_d_reg;
  logic cal_done_rise;
  logic init_reg;
  logic irq_req_reg;
  logic irq_req_next;
  logic cal_pass_reg;
  logic cal_pass_next;
  logic chan_ready_reg;
  logic chan_ready_next;
  logic thresh_reg;
  logic full_reg;
  logic [31:0] rdata_reg;
  bcr_pkg::bcr_pulse_t pulses_reg;
  bcr_pkg::bcr_pulse_t pulses_next;
  logic irq_out_reg;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic hit;
  logic wr_hit;
  logic wr_sync;
  logic wr_cal;
  logic wr_init;
  logic param_change;
  logic [31:0] wd;

  assign hit = (reg_addr == bcr_pkg::BOARD_CONTROL_OFFSET);
  assign wr_hit = reg_wr && hit;
  assign wd = reg_wdata & bcr_pkg::WRITE_MASK;
  assign wr_sync = wr_hit && wd[bcr_pkg::SYNC_BIT];
  assign wr_cal = wr_hit && wd[bcr_pkg::CAL_BIT] && !cal_reg;
  assign wr_init = wr_hit && wd[bcr_pkg::INIT_BIT];

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_init) begin
      ctrl_next = RESET_CTRL;
    end else if (wr_hit) begin
      ctrl_next.input_mode = wd[bcr_pkg::INPUT_MODE_LSB +: 2];
      ctrl_next.input_span = wd[bcr_pkg::INPUT_SPAN_LSB +: 2];
      ctrl_next.offset_binary = wd[bcr_pkg::OFFSET_BINARY_BIT];
      ctrl_next.initiator = wd[bcr_pkg::INITIATOR_BIT];
      ctrl_next.irq_event_sel = wd[bcr_pkg::IRQ_SEL_LSB +: 3];
      ctrl_next.unsynced_sampling = wd[bcr_pkg::UNSYNCED_BIT];
      ctrl_next.clear_on_sync = wd[bcr_pkg::CLR_ON_SYNC_BIT];
      ctrl_next.clock_out_source_sel = wd[bcr_pkg::CLK_OUT_SEL_BIT];
      ctrl_next.low_freq_filter = wd[bcr_pkg::LOW_FILTER_BIT];
      ctrl_next.ttl_sync_io = wd[bcr_pkg::TTL_SYNC_BIT];
      ctrl_next.arm_ext_trigger = wd[bcr_pkg::ARM_TRIG_BIT];
    end
  end

  // channel parameters: anything that alters mode, span, filter, sampling or init
  assign param_change = wr_init || (wr_hit &&
    (ctrl_next.input_mode != ctrl_reg.input_mode ||
     ctrl_next.input_span != ctrl_reg.input_span ||
     ctrl_next.low_freq_filter != ctrl_reg.low_freq_filter ||
     ctrl_next.unsynced_sampling != ctrl_reg.unsynced_sampling));

  // ----------------------------------------------------------------
  // action bits and status flags
  // ----------------------------------------------------------------
  // completion is the rising edge: done stays high from the previous run
  assign cal_done_rise = cal_done_s && !cal_done_d_reg;
  assign cal_next = wr_cal ? 1'b1 : (cal_done_rise ? 1'b0 : cal_reg);
  assign cal_pass_next = wr_cal ? 1'b1 :
    ((cal_reg && cal_done_rise && cal_fail_s) ? 1'b0 : cal_pass_reg);
  assign chan_ready_next = param_change ? 1'b0 : (clocks_stable_s ? 1'b1 : chan_ready_reg);
  // set wins over the software clear
  assign irq_req_next = irq_event_s ? 1'b1 :
                        wr_init ? RESET_VAL[bcr_pkg::IRQ_REQ_BIT] :
                        (wr_hit && !reg_wdata[bcr_pkg::IRQ_REQ_BIT]) ? 1'b0 : irq_req_reg;

  assign pulses_next.sync_start = wr_sync && !ctrl_next.clear_on_sync;
  assign pulses_next.buffer_clear = wr_sync && ctrl_next.clear_on_sync;
  assign pulses_next.ext_sync_out = wr_sync && !ctrl_next.clear_on_sync && ctrl_next.initiator;
  assign pulses_next.cal_start = wr_cal;
  assign pulses_next.board_init = wr_init;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= RESET_CTRL;
      sync_reg <= 1'b0;
      cal_reg <= 1'b0;
      cal_done_d_reg <= 1'b0;
      init_reg <= 1'b0;
      irq_req_reg <= RESET_VAL[bcr_pkg::IRQ_REQ_BIT];
      cal_pass_reg <= 1'b1;
      chan_ready_reg <= 1'b1;
      thresh_reg <= 1'b0;
      full_reg <= 1'b0;
      pulses_reg <= '0;
      irq_out_reg <= RESET_VAL[bcr_pkg::IRQ_REQ_BIT];
    end else begin
      ctrl_reg <= ctrl_next;
      sync_reg <= wr_sync;
      cal_reg <= cal_next;
      cal_done_d_reg <= cal_done_s;
      init_reg <= wr_init;
      irq_req_reg <= irq_req_next;
      cal_pass_reg <= cal_pass_next;
      chan_ready_reg <= chan_ready_next;
      thresh_reg <= above_thresh_s;
      full_reg <= buf_full_s;
      pulses_reg <= pulses_next;
      irq_out_reg <= irq_req_next;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] reg_image;

  assign reg_image = {10'h000, ctrl_reg.arm_ext_trigger, ctrl_reg.ttl_sync_io,
    ctrl_reg.low_freq_filter, ctrl_reg.clock_out_source_sel, ctrl_reg.clear_on_sync,
    ctrl_reg.unsynced_sampling, init_reg, thresh_reg || full_reg, chan_ready_reg,
    cal_pass_reg, irq_req_reg, ctrl_reg.irq_event_sel, cal_reg, sync_reg,
    ctrl_reg.initiator, ctrl_reg.offset_binary, ctrl_reg.input_span,
    ctrl_reg.input_mode};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_reg <= hit ? reg_image : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
  assign ctrl = ctrl_reg;
  assign pulses = pulses_reg;
  assign irq_out = irq_out_reg;

  // ----------------------------------------------------------------
  // external clock output
  // ----------------------------------------------------------------
  logic group0_ext;

  assign group0_ext = (group0_rate_src == bcr_pkg::RATE_SRC_EXT_A) ||
                      (group0_rate_src == bcr_pkg::RATE_SRC_EXT_DIRECT);

  bcr_clk_out #(
    .DIV_WIDTH(DIV_WIDTH)
  ) u_clk_out (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .initiator(ctrl_reg.initiator),
    .sel_rate_a(ctrl_reg.clock_out_source_sel),
    .group0_ext(group0_ext),
    .group0_div(group0_div),
    .rate_a_tick(rate_a_tick),
    .group0_tick(group0_tick),
    .ext_clk_out_reg(ext_clk_out)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_sync_selfclear: assert property (wr_sync |=> sync_reg ##1 !sync_reg || $past(wr_sync, 1))
    else $error("sync bit did not clear after one cycle");
  chk_sync_ext_out: assert property (wr_sync && ctrl_next.initiator && !ctrl_next.clear_on_sync
    |=> pulses.ext_sync_out)
    else $error("initiator sync did not drive the external sync pulse");
  chk_cal_hold: assert property (wr_cal |=> cal_reg)
    else $error("calibration bit not set after start");
  chk_cal_done_clear: assert property (cal_reg && cal_done_rise && !wr_cal |=> !cal_reg)
    else $error("calibration bit not cleared on completion");
  chk_irq_set_wins: assert property (irq_event_s |=> irq_req_reg)
    else $error("interrupt request lost");
  chk_irq_sw_clear: assert property (!irq_event_s && !wr_init && wr_hit &&
    !reg_wdata[bcr_pkg::IRQ_REQ_BIT]
    |=> !irq_req_reg)
    else $error("interrupt request not cleared by write of zero");
  chk_cal_pass_fail: assert property (cal_reg && cal_done_rise && cal_fail_s && !wr_cal
    |=> !cal_pass_reg)
    else $error("calibration pass not cleared on failure");
  chk_ready_drop: assert property (param_change |=> !chan_ready_reg)
    else $error("channels ready stayed high across a change");
  chk_thresh_follow: assert property (above_thresh_s |=> reg_image[bcr_pkg::THRESH_BIT])
    else $error("threshold flag not reported");
  chk_buf_clear_ctx: assert property (wr_sync && ctrl_next.clear_on_sync
    |=> pulses.buffer_clear && !pulses.sync_start)
    else $error("sync not replaced by buffer clear");
  chk_reserved_zero: assert property (reg_image[31:22] == 10'h000)
    else $error("reserved bits read non-zero");
  chk_init_pulse: assert property (wr_init |=> init_reg ##1 (!init_reg || $past(wr_init, 1)))
    else $error("initialize bit did not self-clear");
  chk_init_restore: assert property (wr_init |=> ctrl_reg == RESET_CTRL)
    else $error("initialize did not restore the control fields");
  chk_target_quiet: assert property (!ctrl_reg.initiator |=> !ext_clk_out)
    else $error("external clock driven while target");

  cov_sync: cover property (wr_sync ##1 pulses.ext_sync_out);
  cov_cal_run: cover property (wr_cal ##[1:40] (cal_reg && cal_done_rise));
  cov_cal_fail: cover property (cal_reg && cal_done_rise && cal_fail_s);
  cov_buf_clear: cover property (wr_sync && ctrl_next.clear_on_sync ##1 pulses.buffer_clear);
  cov_irq: cover property (irq_event_s ##1 wr_hit ##1 !irq_req_reg);

endmodule

// ===== bcr_clk_out.sv
// external clock output selector with group-zero divider
`timescale 1ns/1ps
module bcr_clk_out #(
  parameter int DIV_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic initiator,
  input wire logic sel_rate_a,
  input wire logic group0_ext,
  input wire logic [DIV_WIDTH-1:0] group0_div,
  input wire logic rate_a_tick,
  input wire logic group0_tick,
  output logic ext_clk_out_reg
);

  logic [DIV_WIDTH-1:0] cnt_reg;
  logic [DIV_WIDTH-1:0] cnt_next;
  logic div_tick;
  logic src_tick;

  initial begin
    if (DIV_WIDTH < 1) begin
      $error("bcr_clk_out: DIV_WIDTH must be at least 1");
    end
  end

  // divide rate-a ticks by the group-zero divisor (zero or one passes through)
  assign div_tick = rate_a_tick && (cnt_reg == '0);
  assign cnt_next = (!rate_a_tick) ? cnt_reg :
                    (cnt_reg == '0) ? ((group0_div > 1) ? group0_div - 1'b1 : '0) :
                    cnt_reg - 1'b1;
  assign src_tick = sel_rate_a ? rate_a_tick :
                    group0_ext ? div_tick : group0_tick;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      ext_clk_out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (!initiator) begin
        ext_clk_out_reg <= 1'b0;
      end else if (src_tick) begin
        ext_clk_out_reg <= ~ext_clk_out_reg;
      end
    end
  end

endmodule

// ===== bcr_pkg.sv
// package with the board control register layout, reset values and types
package bcr_pkg;

  // ----------------------------------------------------------------
  // register location and width
  // ----------------------------------------------------------------
  localparam logic [7:0] BOARD_CONTROL_OFFSET = 8'h00;
  localparam int REG_WIDTH = 32;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int INPUT_MODE_LSB = 0;
  localparam int INPUT_SPAN_LSB = 2;
  localparam int OFFSET_BINARY_BIT = 4;
  localparam int INITIATOR_BIT = 5;
  localparam int SYNC_BIT = 6;
  localparam int CAL_BIT = 7;
  localparam int IRQ_SEL_LSB = 8;
  localparam int IRQ_REQ_BIT = 11;
  localparam int CAL_PASS_BIT = 12;
  localparam int CHAN_READY_BIT = 13;
  localparam int THRESH_BIT = 14;
  localparam int INIT_BIT = 15;
  localparam int UNSYNCED_BIT = 16;
  localparam int CLR_ON_SYNC_BIT = 17;
  localparam int CLK_OUT_SEL_BIT = 18;
  localparam int LOW_FILTER_BIT = 19;
  localparam int TTL_SYNC_BIT = 20;
  localparam int ARM_TRIG_BIT = 21;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_STD = 32'h0000_383C;
  localparam logic [31:0] RESET_LOWPWR = 32'h0000_3838;
  localparam logic [31:0] WRITE_MASK = 32'h003F_8FFF;
  localparam logic [1:0] SPAN_10V = 2'h3;
  localparam logic [1:0] SPAN_5V = 2'h2;

  // ----------------------------------------------------------------
  // input mode codes and rate assignment codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BCR_MODE_DIFF = 2'h0,
    BCR_MODE_RSVD = 2'h1,
    BCR_MODE_ZERO = 2'h2,
    BCR_MODE_VREF = 2'h3
  } bcr_input_mode_t;

  localparam logic [3:0] RATE_SRC_EXT_A = 4'h4;
  localparam logic [3:0] RATE_SRC_EXT_DIRECT = 4'h5;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] input_mode;
    logic [1:0] input_span;
    logic offset_binary;
    logic initiator;
    logic [2:0] irq_event_sel;
    logic unsynced_sampling;
    logic clear_on_sync;
    logic clock_out_source_sel;
    logic low_freq_filter;
    logic ttl_sync_io;
    logic arm_ext_trigger;
  } bcr_ctrl_t;

  typedef struct packed {
    logic sync_start;
    logic buffer_clear;
    logic ext_sync_out;
    logic cal_start;
    logic board_init;
  } bcr_pulse_t;

endpackage

// ===== bcr_sync2.sv
// two-flip-flop synchroniser for asynchronous status inputs
`timescale 1ns/1ps
module bcr_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("bcr_sync2: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ===== testbench.sv
// self-checking testbench for the board control register
`timescale 1ns/1ps
module testbench;
  logic clk_sys, nrst, reg_wr, reg_rd, irq_event, buf_above_thresh, buf_full;
  logic rate_a_tick, group0_tick, fail_next, cal_done, cal_fail, clocks_stable;
  logic irq_out, ext_clk_out, x;
  logic [7:0] reg_addr, group0_div;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [3:0] group0_rate_src;
  bcr_pkg::bcr_ctrl_t ctrl;
  bcr_pkg::bcr_pulse_t pulses, seen_p;
  int err_count, tests_run;

  bcr_board_control dut (.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_event(irq_event), .cal_done(cal_done), .cal_fail(cal_fail),
    .clocks_stable(clocks_stable), .buf_above_thresh(buf_above_thresh),
    .buf_full(buf_full), .rate_a_tick(rate_a_tick), .group0_tick(group0_tick),
    .group0_rate_src(group0_rate_src), .group0_div(group0_div), .ctrl(ctrl),
    .pulses(pulses), .irq_out(irq_out), .ext_clk_out(ext_clk_out));

  bcr_backend_model backend (.clk_sys(clk_sys), .nrst(nrst), .pulses(pulses), .ctrl(ctrl),
    .fail_next(fail_next), .cal_cycles(8'h14), .cal_done(cal_done),
    .cal_fail(cal_fail), .clocks_stable(clocks_stable));

  // ----------------------------------------------------------------
  // clock, watchdog and closing
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end

  task automatic stop_test();
    $display("checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1 seen_p = pulses;
  endtask

  task automatic rdr(logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic settle();
    repeat (16) @(posedge clk_sys);
  endtask

  task automatic tick(logic rate_a);
    @(posedge clk_sys);
    if (rate_a) begin
      rate_a_tick <= 1'b1;
    end else begin
      group0_tick <= 1'b1;
    end
    @(posedge clk_sys);
    rate_a_tick <= 1'b0;
    group0_tick <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  function automatic bcr_pkg::bcr_ctrl_t exp_ctrl(logic [31:0] v);
    return bcr_pkg::bcr_ctrl_t'({v[1:0], v[3:2], v[4], v[5], v[10:8], v[16], v[17], v[18],
      v[19], v[20], v[21]});
  endfunction

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, reg_wr, reg_rd, irq_event, buf_above_thresh, buf_full} = 6'h00;
    {rate_a_tick, group0_tick, fail_next} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    group0_rate_src = 4'h0;
    group0_div = 8'h02;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    rdr(8'h00);
    check("reset image", rd, bcr_pkg::RESET_STD);
    check("reset ctrl", 32'(ctrl), 32'(exp_ctrl(bcr_pkg::RESET_STD)));
    rdr(8'h04);
    check("unmapped read", rd, 32'h0000_0000);
    wr(8'h04, 32'h0000_0000);
    rdr(8'h00);
    check("unmapped write", rd, bcr_pkg::RESET_STD);
    wr(8'h00, 32'hFFFF_0F3F);
    settle();
    rdr(8'h00);
    check("all fields", rd, 32'h003F_3F3F);
    check("all ctrl", 32'(ctrl), 32'(exp_ctrl(32'h003F_3F3F)));
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'h0000_0030 | 32'(m));
      rdr(8'h00);
      check("input mode", rd[1:0], m[1:0]);
      check("mode ctrl", ctrl.input_mode, m[1:0]);
    end
    wr(8'h00, 32'h0000_8000);
    check("init pulse", seen_p, 5'h01);
    settle();
    rdr(8'h00);
    check("after init", rd, bcr_pkg::RESET_STD);
    wr(8'h00, 32'h0000_0070);
    check("sync initiator", seen_p, 5'h14);
    rdr(8'h00);
    check("sync clears", rd[6], 1'b0);
    wr(8'h00, 32'h0002_0050);
    check("sync clears buffer", seen_p, 5'h08);
    wr(8'h00, 32'h0000_0050);
    check("sync target", seen_p, 5'h10);
    for (int f = 0; f < 2; f++) begin
      fail_next <= f[0];
      wr(8'h00, 32'h0000_00B0);
      check("cal pulse", seen_p, 5'h02);
      rdr(8'h00);
      check("cal running", {rd[12], rd[7]}, 2'h3);
      for (int i = 0; i < 60 && rd[7] !== 1'b0; i++) begin
        rdr(8'h00);
      end
      check("cal ends", rd[7], 1'b0);
      check("cal pass", rd[12], (f == 0));
    end
    @(posedge clk_sys);
    irq_event <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdr(8'h00);
    check("irq flag", {rd[11], irq_out}, 2'h3);
    irq_event <= 1'b0;
    repeat (3) @(posedge clk_sys);
    wr(8'h00, 32'h0000_003C);
    rdr(8'h00);
    check("irq cleared", {rd[11], irq_out}, 2'h0);
    settle();
    buf_full <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdr(8'h00);
    check("buffer full", rd & 32'hFFFF_EFFF, 32'h0000_603C);
    buf_full <= 1'b0;
    buf_above_thresh <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdr(8'h00);
    check("threshold", rd[14], 1'b1);
    buf_above_thresh <= 1'b0;
    wr(8'h00, 32'h0004_0030);
    x = ext_clk_out;
    tick(1'b1);
    check("clk out rate a", ext_clk_out, !x);
    tick(1'b0);
    check("clk out hold", ext_clk_out, !x);
    wr(8'h00, 32'h0000_0030);
    x = ext_clk_out;
    tick(1'b0);
    check("clk out group0", ext_clk_out, !x);
    group0_rate_src <= 4'h4;
    x = ext_clk_out;
    tick(1'b1);
    tick(1'b1);
    check("clk out divided", ext_clk_out, !x);
    tick(1'b1);
    tick(1'b1);
    check("clk out divided again", ext_clk_out, x);
    wr(8'h00, 32'h0000_0010);
    tick(1'b1);
    check("clk out target", ext_clk_out, 1'b0);
    stop_test();
  end
endmodule
